// File: rtl/mcu_pkg.sv
// Purpose: shared constants for the MIDI command/UART host interface
// Assumes: 250 MHz system clock, 32-bit Avalon-MM register bus
// Notes:   byte address of a config register is four times its index
package mcu_pkg;
  // clock and line timing
  localparam int unsigned MCU_CLK_MHZ       = 250;
  localparam int unsigned MCU_BIT_PERIOD_US = 32;
  localparam int unsigned MCU_BIT_CYC       = MCU_BIT_PERIOD_US * MCU_CLK_MHZ;
  localparam int unsigned MCU_FRAME_BITS    = 10;
  localparam int unsigned MCU_DATA_BITS     = 8;
  localparam int unsigned MCU_FIFO_DEPTH    = 16;

  // command codes and the acknowledge byte
  localparam logic [7:0] MCU_CMD_RESET = 8'hFF;
  localparam logic [7:0] MCU_CMD_THRU  = 8'h3F;
  localparam logic [7:0] MCU_ACK_BYTE  = 8'hFE;

  // status port layout
  localparam int unsigned MCU_ST_EMPTY_BIT = 7;
  localparam int unsigned MCU_ST_BUSY_BIT  = 6;
  localparam logic [7:0]  MCU_STATUS_RST   = 8'h80;

  // address map: bit 18 set selects the host I/O window
  localparam int unsigned MCU_ADDR_W       = 19;
  localparam int unsigned MCU_IO_SPACE_BIT = 18;
  localparam int unsigned MCU_IO_MSB       = 17;
  localparam int unsigned MCU_IO_LSB       = 2;
  localparam int unsigned MCU_IDX_MSB      = 9;
  localparam logic [7:0]  MCU_IDX_ACTIVATE = 8'h30;
  localparam logic [7:0]  MCU_IDX_BASE_HI  = 8'h60;
  localparam logic [7:0]  MCU_IDX_BASE_LO  = 8'h61;
  localparam int unsigned MCU_ACT_BIT      = 0;
  localparam logic [15:0] MCU_IO_BASE_RST  = 16'h0330;

  typedef enum logic {
    MCU_MODE_RESET = 1'b0,
    MCU_MODE_THRU  = 1'b1
  } mcu_mode_e;

  typedef enum logic [1:0] {
    MCU_RS_NONE = 2'b00,
    MCU_RS_ACK  = 2'b01,
    MCU_RS_FIFO = 2'b11,
    MCU_RS_REG  = 2'b10
  } mcu_rsrc_e;

  typedef enum logic [1:0] {
    MCU_RX_IDLE  = 2'b00,
    MCU_RX_START = 2'b01,
    MCU_RX_DATA  = 2'b11,
    MCU_RX_STOP  = 2'b10
  } mcu_rx_e;
endpackage

// File: rtl/mcu_midi_uart.sv
// Purpose: MIDI host interface: command controller, pass-through UART, config
// Assumes: one clock; Avalon-MM master holds requests until waitrequest is low
// Notes:   every access takes one wait cycle; FIFO depth must be a power of two
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps

module mcu_midi_uart
  import mcu_pkg::*;
#(
  parameter int unsigned BIT_CYC    = MCU_BIT_CYC,
  parameter int unsigned FIFO_DEPTH = MCU_FIFO_DEPTH
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [MCU_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic                  midi_serial_input_i,
  output logic                       midi_serial_output_o,
  output logic                       irq_o,
  output logic                       powered_o
);
  localparam int unsigned PW = $clog2(FIFO_DEPTH);
  localparam int unsigned CW = $clog2(BIT_CYC);
  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYC / 2 - 1);
  localparam logic [3:0] FRAME_N = 4'(MCU_FRAME_BITS);
  localparam logic [2:0] DATA_LAST = 3'(MCU_DATA_BITS - 1);

  logic            ack_reg;
  mcu_mode_e       mode_reg;
  mcu_rsrc_e       rsrc_reg;
  logic            ack_pend_reg;
  logic            act_reg;
  logic [7:0]      base_hi_reg;
  logic [7:0]      base_lo_reg;
  logic [7:0]      rdata_reg;
  logic            irq_reg;
  logic [1:0]      f_push;
  logic [1:0]      f_pop;
  logic [1:0]      f_clr;
  logic [1:0]      f_full;
  logic [1:0]      f_empty;
  logic [7:0]      f_wd [2];
  logic [7:0]      f_rd [2];
  logic [9:0]      tx_sh_reg;
  logic [3:0]      tx_bits_reg;
  logic [CW-1:0]   tx_cnt_reg;
  logic            rx_s1_reg;
  logic            rx_s2_reg;
  logic            rx_s3_reg;
  mcu_rx_e         rx_st_reg;
  logic [CW-1:0]   rx_cnt_reg;
  logic [2:0]      rx_bit_reg;
  logic [7:0]      rx_sh_reg;
  logic            rx_done_reg;
  logic [7:0]      status;
  logic [7:0]      cfg_rd;

  // bus handshake: first cycle waits, second completes the access
  wire req     = avs_read_i | avs_write_i;
  wire rd_done = avs_read_i & ack_reg;
  wire wr_done = avs_write_i & ack_reg;
  assign avs_waitrequest_o = req & ~ack_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  // address decode; the I/O window only answers while activated
  wire [15:0] io_adr = avs_address_i[MCU_IO_MSB:MCU_IO_LSB];
  wire [7:0]  cfg_idx = avs_address_i[MCU_IDX_MSB:MCU_IO_LSB];
  wire io_cyc  = avs_address_i[MCU_IO_SPACE_BIT];
  wire io_hit  = io_cyc & act_reg & (io_adr[15:1] == {base_hi_reg, base_lo_reg[7:1]});
  wire data_sel = io_hit & ~io_adr[0];
  wire cmd_sel  = io_hit & io_adr[0];
  wire cfg_sel  = ~io_cyc;
  wire [7:0] wbyte = avs_writedata_i[7:0];
  wire thru = (mode_reg == MCU_MODE_THRU);

  // command interpreter; unknown codes fall through untouched
  wire cmd_wr   = wr_done & cmd_sel;
  wire cmd_rst  = cmd_wr & (wbyte == MCU_CMD_RESET);
  wire cmd_thru = cmd_wr & (wbyte == MCU_CMD_THRU) & ~thru;

  // mode: power-on and the reset command both land in reset state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      mode_reg <= MCU_MODE_RESET;
    else if (cmd_rst)
      mode_reg <= MCU_MODE_RESET;
    else if (cmd_thru)
      mode_reg <= MCU_MODE_THRU;
  end

  // pending acknowledge byte, always served ahead of FIFO data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      ack_pend_reg <= 1'b0;
    else if (cmd_rst)
      ack_pend_reg <= ~thru;
    else if (cmd_thru)
      ack_pend_reg <= 1'b1;
    else if (rd_done && rsrc_reg == MCU_RS_ACK)
      ack_pend_reg <= 1'b0;
  end

  // configuration registers: activate and I/O base
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      act_reg     <= 1'b0;
      base_hi_reg <= MCU_IO_BASE_RST[15:8];
      base_lo_reg <= MCU_IO_BASE_RST[7:0];
    end else if (wr_done && cfg_sel) begin
      if (cfg_idx == MCU_IDX_ACTIVATE)
        act_reg <= wbyte[MCU_ACT_BIT];
      if (cfg_idx == MCU_IDX_BASE_HI)
        base_hi_reg <= wbyte;
      if (cfg_idx == MCU_IDX_BASE_LO)
        base_lo_reg <= wbyte;
    end
  end
  assign powered_o = act_reg;

  // status port; busy means the transmit FIFO cannot take a byte
  wire rx_empty = ~ack_pend_reg & f_empty[1];
  always_comb begin
    status = '0;
    status[MCU_ST_EMPTY_BIT] = rx_empty;
    status[MCU_ST_BUSY_BIT]  = f_full[0];
  end
  always_comb begin
    case (cfg_idx)
      MCU_IDX_ACTIVATE: cfg_rd = 8'(act_reg);
      MCU_IDX_BASE_HI:  cfg_rd = base_hi_reg;
      MCU_IDX_BASE_LO:  cfg_rd = base_lo_reg;
      default:          cfg_rd = '0;
    endcase
  end

  // read data is chosen in the wait cycle so a byte landing in the
  // FIFO during the access cannot change which entry gets popped
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
      rsrc_reg  <= MCU_RS_NONE;
    end else if (avs_read_i && !ack_reg) begin
      rsrc_reg  <= MCU_RS_REG;
      rdata_reg <= '0;
      if (data_sel && ack_pend_reg) begin
        rsrc_reg  <= MCU_RS_ACK;
        rdata_reg <= MCU_ACK_BYTE;
      end else if (data_sel && !f_empty[1]) begin
        rsrc_reg  <= MCU_RS_FIFO;
        rdata_reg <= f_rd[1];
      end else if (cmd_sel)
        rdata_reg <= status;
      else if (cfg_sel)
        rdata_reg <= cfg_rd;
    end
  end
  assign avs_readdata_o = 32'(rdata_reg);

  // interrupt follows data-available, gated by activate
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= act_reg & ~rx_empty;
  end
  assign irq_o = irq_reg;
  // FIFO hookup: channel 0 transmit, channel 1 receive
  wire uart_on = act_reg & thru;
  wire tx_load = uart_on & (tx_bits_reg == '0) & ~f_empty[0];
  assign f_clr[0]  = cmd_thru;
  assign f_clr[1]  = cmd_rst | cmd_thru;
  assign f_push[0] = wr_done & data_sel & thru;
  assign f_push[1] = rx_done_reg & thru;
  assign f_wd[0]   = wbyte;
  assign f_wd[1]   = rx_sh_reg;
  assign f_pop[0]  = tx_load;
  assign f_pop[1]  = rd_done & (rsrc_reg == MCU_RS_FIFO);

  // two identical FIFOs; a push into a full one is dropped
  for (genvar g = 0; g < 2; g++) begin : g_fifo
    logic [7:0]    mem [FIFO_DEPTH];
    logic [PW-1:0] wp_reg;
    logic [PW-1:0] rp_reg;
    logic [PW:0]   cnt_reg;
    wire do_push = f_push[g] & ~f_full[g];
    wire do_pop  = f_pop[g] & ~f_empty[g];
    assign f_full[g]  = (cnt_reg == (PW+1)'(FIFO_DEPTH));
    assign f_empty[g] = (cnt_reg == '0);
    assign f_rd[g]    = mem[rp_reg];
    always_ff @(posedge sys_clk_i) begin
      if (do_push)
        mem[wp_reg] <= f_wd[g];
    end
    // clearing wins over a push or pop in the same cycle
    always_ff @(posedge sys_clk_i) begin
      if (rst_i || f_clr[g]) begin
        wp_reg  <= '0;
        rp_reg  <= '0;
        cnt_reg <= '0;
      end else begin
        if (do_push)
          wp_reg <= wp_reg + 1'b1;
        if (do_pop)
          rp_reg <= rp_reg + 1'b1;
        if (do_push && !do_pop)
          cnt_reg <= cnt_reg + 1'b1;
        else if (do_pop && !do_push)
          cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // transmitter: stop, data, start loaded; shifted out LSB first
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_sh_reg   <= '1;
      tx_bits_reg <= '0;
      tx_cnt_reg  <= '0;
    end else if (tx_load) begin
      tx_sh_reg   <= {1'b1, f_rd[0], 1'b0};
      tx_bits_reg <= FRAME_N;
      tx_cnt_reg  <= BIT_LAST;
    end else if (tx_bits_reg != '0) begin
      if (tx_cnt_reg == '0) begin
        tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
        tx_bits_reg <= tx_bits_reg - 1'b1;
        tx_cnt_reg  <= BIT_LAST;
      end else
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end
  assign midi_serial_output_o = tx_sh_reg[0];
  // input synchroniser; third stage only feeds the edge detector
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
    end else begin
      rx_s1_reg <= midi_serial_input_i;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end
  // receiver: mid-bit sampling; a low stop bit drops the frame
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_st_reg   <= MCU_RX_IDLE;
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= '0;
      rx_sh_reg   <= '0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (rx_cnt_reg != '0)
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      case (rx_st_reg)
        MCU_RX_IDLE: if (uart_on && rx_s3_reg && !rx_s2_reg) begin
          rx_st_reg  <= MCU_RX_START;
          rx_cnt_reg <= HALF_LAST;
        end
        MCU_RX_START: if (rx_cnt_reg == '0) begin
          rx_st_reg  <= rx_s2_reg ? MCU_RX_IDLE : MCU_RX_DATA;
          rx_cnt_reg <= BIT_LAST;
          rx_bit_reg <= '0;
        end
        MCU_RX_DATA: if (rx_cnt_reg == '0) begin
          rx_sh_reg  <= {rx_s2_reg, rx_sh_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 1'b1;
          rx_cnt_reg <= BIT_LAST;
          if (rx_bit_reg == DATA_LAST)
            rx_st_reg <= MCU_RX_STOP;
        end
        MCU_RX_STOP: if (rx_cnt_reg == '0) begin
          rx_done_reg <= rx_s2_reg;
          rx_st_reg   <= MCU_RX_IDLE;
        end
        default: rx_st_reg <= MCU_RX_IDLE;
      endcase
    end
  end
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cmd(logic [7:0] code);
    cmd_wr && wbyte == code;
  endsequence
  sequence s_ack_served;
    (rsrc_reg == MCU_RS_ACK && rdata_reg == MCU_ACK_BYTE) ##1 !ack_pend_reg;
  endsequence
  property p_cmd_ignored;
    cmd_wr && wbyte != MCU_CMD_RESET && wbyte != MCU_CMD_THRU |=> $stable(mode_reg) && $stable(ack_pend_reg);
  endproperty
  a_cmd_ignored: assert property (p_cmd_ignored) else $error("unknown command changed state");
  property p_rst_cmd;
    s_cmd(MCU_CMD_RESET) |=> mode_reg == MCU_MODE_RESET && f_empty[1];
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("reset command did not reset");
  property p_rst_ack;
    s_cmd(MCU_CMD_RESET) ##0 !thru |=> ack_pend_reg && !status[MCU_ST_EMPTY_BIT] ##1 irq_o == act_reg;
  endproperty
  a_rst_ack: assert property (p_rst_ack) else $error("reset acknowledge missing");
  property p_rst_noack;
    s_cmd(MCU_CMD_RESET) ##0 thru |=> !ack_pend_reg;
  endproperty
  a_rst_noack: assert property (p_rst_noack) else $error("acknowledge in pass-through");
  // in reset state neither host writes nor serial bytes may reach a FIFO
  property p_rx_drop;
    !thru && !f_clr[0] |=> f_empty[1] && $stable(f_empty[0]);
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("data kept in reset state");
  property p_thru_cmd;
    s_cmd(MCU_CMD_THRU) ##0 !thru |=> thru && f_empty == 2'b11 && ack_pend_reg;
  endproperty
  a_thru_cmd: assert property (p_thru_cmd) else $error("pass-through entry wrong");
  property p_thru_again;
    s_cmd(MCU_CMD_THRU) ##0 (thru && !ack_pend_reg) |=> thru && !ack_pend_reg;
  endproperty
  a_thru_again: assert property (p_thru_again) else $error("repeat 3Fh not ignored");
  property p_ack_first;
    avs_read_i && !ack_reg && data_sel && ack_pend_reg |=> s_ack_served;
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("acknowledge not read first");
  // the byte is compared once, right after the load; the pop has moved the FIFO head on by then
  property p_tx_frame;
    tx_load |=> tx_sh_reg[8:1] == $past(f_rd[0]) ##0 (!midi_serial_output_o) [*8];
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("bad transmit start");
  property p_irq_off;
    !act_reg |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while inactive");
  property p_overrun;
    f_push[1] && f_full[1] && !f_pop[1] && !f_clr[1] |=> f_full[1] && $stable(f_rd[1]);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun disturbed FIFO");
endmodule

// File: verification/mcu_line_model.sv
// Purpose: far side of the MIDI serial link: sends frames, decodes frames
// Assumes: line idles high; bit time given in system clock cycles
// Notes:   decoded bytes wait in rx_q for the bench to inspect
`timescale 1ns/100ps
module mcu_line_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic sys_clk_i,
  input  wire logic line_from_dut_i,
  output logic      line_to_dut_o
);
  logic [7:0] rx_q[$];
  logic [7:0] b;

  // idle level before the first frame
  initial begin
    line_to_dut_o = 1'b1;
  end

  // start bit, eight data bits lsb first, one stop bit; gap gives a slow sender
  task automatic send(input logic [7:0] d, input int gap);
    for (int i = 0; i < 10; i++) begin
      line_to_dut_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (BIT_CYC) @(posedge sys_clk_i);
    end
    repeat (gap) @(posedge sys_clk_i);
  endtask

  // receiver samples mid-bit, so a wrong bit time or order shows as a bad byte
  always begin
    @(negedge line_from_dut_i);
    repeat (BIT_CYC / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk_i);
      b[i] = line_from_dut_i;
    end
    repeat (BIT_CYC) @(posedge sys_clk_i);
    if (line_from_dut_i === 1'b1) begin
      rx_q.push_back(b);
    end
  end
endmodule

// File: verification/midi_command_uart_tb.sv
// Purpose: self-checking bench for the MIDI command/UART block
// Assumes: line model on the serial pins, shortened bit time
// Notes:   one task per scenario; summarize closes the run
`timescale 1ns/100ps
module midi_command_uart_tb;
  import mcu_pkg::*;
  localparam int BC = 16;
  logic        sys_clk_i;
  logic        rst_i;
  logic [18:0] adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wait_req;
  logic        ser_in;
  logic        ser_out;
  logic        irq;
  logic        pwr;
  logic [15:0] base;
  logic [7:0]  q;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  mcu_midi_uart #(.BIT_CYC(BC), .FIFO_DEPTH(16)) mcu_midi_uart_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
    .midi_serial_input_i(ser_in), .midi_serial_output_o(ser_out), .irq_o(irq), .powered_o(pwr));
  mcu_line_model #(.BIT_CYC(BC)) mcu_line_model_i (
    .sys_clk_i(sys_clk_i), .line_from_dut_i(ser_out), .line_to_dut_o(ser_in));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // hang guard: a stuck handshake or frame ends the run as a failure
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize;
    end
  end

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one Avalon access; waitrequest and readdata are taken at the rising edge, before the registers
  // move; the request stands until that edge and only the hang guard can end the wait
  task automatic bus(input logic w, input logic [18:0] a, input logic [7:0] d, output logic [7:0] r);
    logic ws;
    adr  <= a;
    wdat <= {24'h0, d};
    wr   <= w;
    rd   <= ~w;
    do begin
      @(posedge sys_clk_i);
      ws = wait_req;
      r = rdat[7:0];
    end while (ws !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, {9'h0, idx, 2'b00}, d, q);
  endtask

  task automatic io_wr(input logic [15:0] off, input logic [7:0] d);
    bus(1'b1, {1'b1, base + off, 2'b00}, d, q);
  endtask

  task automatic io_rd(input logic [15:0] off, input logic [7:0] exp, input string m);
    bus(1'b0, {1'b1, base + off, 2'b00}, 8'h00, q);
    chk(q, exp, m);
  endtask

  // irq and power pins, looked at once the registered outputs have settled
  task automatic pins(input logic ei, input logic ep, input string m);
    @(negedge sys_clk_i);
    chk({6'h0, irq, pwr}, {6'h0, ei, ep}, m);
    @(posedge sys_clk_i);
  endtask

  task automatic t_reset;
    bus(1'b0, {9'h0, MCU_IDX_BASE_HI, 2'b00}, 8'h00, q);
    chk(q, MCU_IO_BASE_RST[15:8], "base high reset");
    io_rd(1, 8'h00, "ports hidden while inactive");
    pins(1'b0, 1'b0, "inactive pins");
    cfg_wr(MCU_IDX_ACTIVATE, 8'h01);
    pins(1'b0, 1'b1, "powered");
    io_rd(1, MCU_STATUS_RST, "status after reset");
    cfg_wr(MCU_IDX_BASE_LO, 8'h00);
    base = 16'h0300;
    io_rd(16'h0031, 8'h00, "old base gone");
    io_rd(1, MCU_STATUS_RST, "new base");
    $display("test reset done");
  endtask

  task automatic t_cmd;
    io_wr(1, 8'h01);
    io_rd(1, 8'h80, "unknown command ignored");
    io_wr(1, MCU_CMD_RESET);
    pins(1'b1, 1'b1, "irq on ack");
    io_rd(1, 8'h00, "ack pending status");
    io_rd(0, MCU_ACK_BYTE, "reset ack");
    pins(1'b0, 1'b1, "irq off after read");
    io_wr(0, 8'h55);
    mcu_line_model_i.send(8'h66, 2 * BC);
    io_rd(1, 8'h80, "reset state discards");
    $display("test commands done");
  endtask

  task automatic t_thru;
    io_wr(1, MCU_CMD_THRU);
    io_rd(0, MCU_ACK_BYTE, "thru ack");
    io_wr(0, 8'hA5);
    mcu_line_model_i.send(8'h3C, 0);
    io_wr(1, MCU_CMD_THRU);
    pins(1'b1, 1'b1, "irq on rx data");
    io_rd(0, 8'h3C, "rx kept, no second ack");
    io_rd(1, 8'h80, "rx drained");
    repeat (4 * BC) @(posedge sys_clk_i);
    chk(8'(mcu_line_model_i.rx_q.size()), 8'h01, "one tx frame");
    chk(mcu_line_model_i.rx_q.pop_front(), 8'hA5, "tx byte");
    $display("test pass-through done");
  endtask

  task automatic t_flow;
    for (int i = 0; i < 17; i++) begin
      mcu_line_model_i.send(8'(i + 16), 0);
    end
    for (int i = 0; i < 16; i++) begin
      io_rd(0, 8'(i + 16), "rx order");
    end
    io_rd(1, 8'h80, "overflow byte dropped");
    for (int i = 0; i < 17; i++) begin
      io_wr(0, 8'(i + 64));
    end
    io_rd(1, 8'hC0, "tx full busy");
    repeat (18 * 10 * BC) @(posedge sys_clk_i);
    for (int i = 0; i < 16; i++) begin
      chk(mcu_line_model_i.rx_q.pop_front(), 8'(i + 64), "tx order");
    end
    mcu_line_model_i.rx_q.delete();
    $display("test fifo depth done");
  endtask

  task automatic t_reset_thru;
    mcu_line_model_i.send(8'h77, 0);
    io_wr(1, MCU_CMD_RESET);
    io_rd(1, 8'h80, "no ack, rx cleared");
    pins(1'b0, 1'b1, "irq quiet after reset");
    mcu_line_model_i.send(8'h12, 2 * BC);
    io_rd(1, 8'h80, "uart disabled");
    io_wr(1, MCU_CMD_RESET);
    io_rd(0, MCU_ACK_BYTE, "ack in reset state");
    $display("test reset in pass-through done");
  endtask

  // reset, then the scenarios in order
  initial begin
    rst_i = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wdat = '0;
    base = MCU_IO_BASE_RST;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset;
    t_cmd;
    t_thru;
    t_flow;
    t_reset_thru;
    summarize;
  end
endmodule
